// ### rtl/spcs_map.svh
// Purpose: Offsets, field positions, reset values and counts of the port register bank
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Bank-relative offsets are not all multiples of four, so each is an index
`ifndef SPCS_MAP_SVH
`define SPCS_MAP_SVH

`define SPCS_IDX_P2_CTRL4      6'h00
`define SPCS_IDX_P2_STATUS     6'h04
`define SPCS_IDX_HP_CTRL1      6'h08
`define SPCS_IDX_HP_CTRL2      6'h0a
`define SPCS_IDX_HP_VID        6'h0c
`define SPCS_IDX_HP_CTRL3      6'h0e
`define SPCS_IDX_HP_IRATE      6'h10
`define SPCS_IDX_HP_ERATE      6'h12
`define SPCS_IDX_CNT_SEL       6'h14
`define SPCS_IDX_CNT_DATA      6'h15

`define SPCS_CTRL4_RST         16'h009f
`define SPCS_CTRL4_WMASK       16'hffff
`define SPCS_STAT_RST          16'h8000
`define SPCS_STAT_WMASK        16'h8000
`define SPCS_HPC2_RST          16'h0607
`define SPCS_HPC2_WMASK        16'h67ef
`define SPCS_PHY_CTL_RST       10'h13f
`define SPCS_SW_CTL_RST        12'h307

`define SPCS_B_FAR_LOOP        8
`define SPCS_B_AUTONEG         7
`define SPCS_B_FSPEED          6
`define SPCS_B_FDUPLEX         5
`define SPCS_B_XSTYLE          15
`define SPCS_B_POLREV          13
`define SPCS_B_RXFC            12
`define SPCS_B_TXFC            11
`define SPCS_B_SPEED           10
`define SPCS_B_DUPLEX          9
`define SPCS_B_MDIX            7
`define SPCS_B_ANDONE          6
`define SPCS_B_LINK            5
`define SPCS_B_VLAN_FILT       14
`define SPCS_B_NON_PORT_DEFAULT_VLAN_ID        13
`define SPCS_B_TX_EN           10
`define SPCS_B_RX_EN           9
`define SPCS_B_LEARN_OFF       8
`define SPCS_B_MON_DEST        7
`define SPCS_B_RX_MIRROR       6
`define SPCS_B_TX_MIRROR       5
`define SPCS_B_PRIO_CEIL       3

`define SPCS_CNT_NUM           34
`define SPCS_CNT_OVF           31
`define SPCS_CNT_VALID         30
`define SPCS_CNT_MAX           30'h3fff_ffff

`endif

// ### rtl/spcs_pkg.sv
// Purpose: Types shared by the port register bank
// Assumes: Constants live in spcs_map.svh
// Notes:   None
package spcs_pkg;

    typedef struct packed {
        logic [5:0] idx;
        logic       wr;
        logic [31:0] wdata;
    } spcs_req_t;

    typedef struct packed {
        logic       polarity_rev;
        logic       rx_flow_active;
        logic       tx_flow_active;
        logic       speed_100;
        logic       full_duplex;
        logic       mdi;
        logic       autoneg_done;
        logic       link_good;
        logic [4:0] partner_abil;
    } spcs_phy_stat_t;

    typedef struct packed {
        logic       far_loopback;
        logic       autoneg_en;
        logic       force_100;
        logic       force_full;
        logic [4:0] advert;
        logic       crossover_style_select;
    } spcs_phy_ctl_t;

    typedef struct packed {
        logic       vlan_filter;
        logic       drop_non_default_vid;
        logic       tx_en;
        logic       rx_en;
        logic       learn_off;
        logic       mon_dest;
        logic       rx_mirror;
        logic       tx_mirror;
        logic       prio_ceiling;
        logic [2:0] member;
    } spcs_sw_ctl_t;

    typedef enum logic [2:0] {
        SPCS_IDLE = 3'b001,
        SPCS_SETUP = 3'b010,
        SPCS_DONE = 3'b100
    } spcs_state_t;

    typedef struct packed {
        spcs_state_t    st;
        logic [15:0]    ctrl4;
        logic [15:0]    status;
        logic [15:0]    hpc1;
        logic [15:0]    hpc2;
        logic [15:0]    hvid;
        logic [15:0]    hpc3;
        logic [15:0]    hirate;
        logic [15:0]    herate;
        logic [5:0]     cnt_sel;
        logic [31:0]    prdata;
        logic           pready;
        logic           pslverr;
        spcs_phy_ctl_t  phy_ctl;
        spcs_sw_ctl_t   sw_ctl;
        logic           link_up;
        logic           rx_link_mode;
    } spcs_state_s_t;

endpackage

// ### rtl/spcs_regs.sv
// Purpose: Port 2 PHY control/status and host port control registers, with counters
// Assumes: Single pclk domain; PHY status and events arrive asynchronously
// Notes:   APB slave answers one cycle after the access phase starts
`include "spcs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module spcs_regs
    import spcs_pkg::*;
(
    // Clock, enable and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // PHY status from the port 2 transceiver
    input  wire spcs_phy_stat_t    phy_stat,
    // Counted events, one per counter, from the port datapath
    input  wire logic [33:0]       cnt_event,
    // Controls to the PHY and switch engine
    output spcs_phy_ctl_t          phy_ctl,
    output spcs_sw_ctl_t           sw_ctl,
    output logic                   link_up
);

    spcs_state_s_t s_q;
    spcs_state_s_t s_d;
    spcs_phy_stat_t stat_m_q;
    spcs_phy_stat_t stat_s_q;
    logic [33:0] ev_m_q;
    logic [33:0] ev_s_q;
    logic [33:0] ev_p_q;
    logic [29:0] cnt_val_q [`SPCS_CNT_NUM];
    logic [`SPCS_CNT_NUM-1:0] cnt_ovf_q;
    logic [`SPCS_CNT_NUM-1:0] cnt_clr;
    logic [5:0] idx;
    logic acc;

    assign idx = paddr[7:2];
    assign acc = psel && penable && (s_q.st == SPCS_SETUP);

    // Two-stage synchronisers; first stage read only by the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_m_q <= '0;
            stat_s_q <= '0;
            ev_m_q <= '0;
            ev_s_q <= '0;
            ev_p_q <= '0;
        end
        else if (clk_en)
        begin
            stat_m_q <= phy_stat;
            stat_s_q <= stat_m_q;
            ev_m_q <= cnt_event;
            ev_s_q <= ev_m_q;
            ev_p_q <= ev_s_q;
        end
    end

    // Counters: an event in the read cycle starts the new count at one
    for (genvar i = 0; i < `SPCS_CNT_NUM; i++)
    begin : g_cnt
        logic inc;
        assign inc = ev_s_q[i] && !ev_p_q[i];
        assign cnt_clr[i] = acc && !pwrite && (idx == `SPCS_IDX_CNT_DATA)
                            && (s_q.cnt_sel == 6'(i));
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                cnt_val_q[i] <= '0;
                cnt_ovf_q[i] <= 1'b0;
            end
            else if (clk_en)
            begin
                if (cnt_clr[i])
                begin
                    cnt_val_q[i] <= {29'h0000_0000, inc};
                    cnt_ovf_q[i] <= 1'b0;
                end
                else if (inc)
                begin
                    cnt_val_q[i] <= cnt_val_q[i] + 30'h0000_0001;
                    if (cnt_val_q[i] == `SPCS_CNT_MAX)
                        cnt_ovf_q[i] <= 1'b1;
                end
            end
        end
    end

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] m);
        merge = (old & ~m) | (pwdata[15:0] & m);
    endfunction

    always_comb
    begin
        logic [31:0] rd;
        logic        hit;
        logic        an_fail;
        rd = '0;
        hit = 1'b1;
        an_fail = 1'b0;
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        unique case (s_q.st)
            SPCS_IDLE:
            begin
                if (psel && !penable)
                    s_d.st = SPCS_SETUP;
            end
            SPCS_SETUP:
            begin
                if (acc)
                begin
                    case (idx)
                        `SPCS_IDX_P2_CTRL4:  rd = {16'h0000, s_q.ctrl4};
                        `SPCS_IDX_P2_STATUS: rd = {16'h0000, s_q.status};
                        `SPCS_IDX_HP_CTRL1:  rd = {16'h0000, s_q.hpc1};
                        `SPCS_IDX_HP_CTRL2:  rd = {16'h0000, s_q.hpc2};
                        `SPCS_IDX_HP_VID:    rd = {16'h0000, s_q.hvid};
                        `SPCS_IDX_HP_CTRL3:  rd = {16'h0000, s_q.hpc3};
                        `SPCS_IDX_HP_IRATE:  rd = {16'h0000, s_q.hirate};
                        `SPCS_IDX_HP_ERATE:  rd = {16'h0000, s_q.herate};
                        `SPCS_IDX_CNT_SEL:   rd = {26'h000_0000, s_q.cnt_sel};
                        `SPCS_IDX_CNT_DATA:
                        begin
                            // Out-of-range select reads invalid
                            if (s_q.cnt_sel < 6'(`SPCS_CNT_NUM))
                                rd = {cnt_ovf_q[s_q.cnt_sel], 1'b1,
                                      cnt_val_q[s_q.cnt_sel]};
                        end
                        default:             hit = 1'b0;
                    endcase
                    if (pwrite && hit)
                    begin
                        case (idx)
                            `SPCS_IDX_P2_CTRL4:
                                s_d.ctrl4 = merge(s_q.ctrl4, `SPCS_CTRL4_WMASK);
                            `SPCS_IDX_P2_STATUS:
                                s_d.status = merge(s_q.status, `SPCS_STAT_WMASK);
                            `SPCS_IDX_HP_CTRL1:  s_d.hpc1 = pwdata[15:0];
                            `SPCS_IDX_HP_CTRL2:
                                s_d.hpc2 = merge(s_q.hpc2, `SPCS_HPC2_WMASK);
                            `SPCS_IDX_HP_VID:    s_d.hvid = pwdata[15:0];
                            `SPCS_IDX_HP_CTRL3:  s_d.hpc3 = pwdata[15:0];
                            `SPCS_IDX_HP_IRATE:  s_d.hirate = pwdata[15:0];
                            `SPCS_IDX_HP_ERATE:  s_d.herate = pwdata[15:0];
                            `SPCS_IDX_CNT_SEL:   s_d.cnt_sel = pwdata[5:0];
                            default:             s_d.cnt_sel = s_q.cnt_sel;
                        endcase
                    end
                    s_d.prdata = pwrite ? 32'h0000_0000 : rd;
                    s_d.pready = 1'b1;
                    s_d.pslverr = !hit;
                    s_d.st = SPCS_DONE;
                end
                else if (!psel)
                    s_d.st = SPCS_IDLE;
            end
            SPCS_DONE:
            begin
                s_d.st = (psel && !penable) ? SPCS_SETUP : SPCS_IDLE;
            end
            default:
                s_d.st = SPCS_IDLE;
        endcase

        // Status mirrors the synchronised PHY every cycle
        s_d.status[`SPCS_B_POLREV] = stat_s_q.polarity_rev;
        s_d.status[`SPCS_B_RXFC] = stat_s_q.rx_flow_active;
        s_d.status[`SPCS_B_TXFC] = stat_s_q.tx_flow_active;
        s_d.status[`SPCS_B_SPEED] = stat_s_q.speed_100;
        s_d.status[`SPCS_B_DUPLEX] = stat_s_q.full_duplex;
        s_d.status[`SPCS_B_MDIX] = stat_s_q.mdi;
        s_d.status[`SPCS_B_ANDONE] = stat_s_q.autoneg_done;
        s_d.status[`SPCS_B_LINK] = stat_s_q.link_good;
        s_d.status[4:0] = stat_s_q.partner_abil;
        s_d.status[14] = 1'b0;
        s_d.status[8] = 1'b0;

        // PHY controls from the stored control word, force_full also gated by synchronised autoneg/link status; crossover style from status bit 15
        an_fail = s_q.ctrl4[`SPCS_B_AUTONEG] && stat_s_q.autoneg_done
                  && !stat_s_q.link_good;
        s_d.phy_ctl.far_loopback = s_q.ctrl4[`SPCS_B_FAR_LOOP];
        s_d.phy_ctl.autoneg_en = s_q.ctrl4[`SPCS_B_AUTONEG];
        s_d.phy_ctl.force_100 = s_q.ctrl4[`SPCS_B_FSPEED];
        s_d.phy_ctl.force_full = s_q.ctrl4[`SPCS_B_FDUPLEX]
            && (!s_q.ctrl4[`SPCS_B_AUTONEG] || an_fail);
        s_d.phy_ctl.advert = s_q.ctrl4[4:0];
        s_d.phy_ctl.crossover_style_select = s_q.status[`SPCS_B_XSTYLE];

        // Switch controls of the host port
        s_d.sw_ctl.vlan_filter = s_q.hpc2[`SPCS_B_VLAN_FILT];
        s_d.sw_ctl.drop_non_default_vid = s_q.hpc2[`SPCS_B_NON_PORT_DEFAULT_VLAN_ID];
        s_d.sw_ctl.tx_en = s_q.hpc2[`SPCS_B_TX_EN];
        s_d.sw_ctl.rx_en = s_q.hpc2[`SPCS_B_RX_EN];
        s_d.sw_ctl.learn_off = s_q.hpc2[`SPCS_B_LEARN_OFF];
        s_d.sw_ctl.mon_dest = s_q.hpc2[`SPCS_B_MON_DEST];
        s_d.sw_ctl.rx_mirror = s_q.hpc2[`SPCS_B_RX_MIRROR];
        s_d.sw_ctl.tx_mirror = s_q.hpc2[`SPCS_B_TX_MIRROR];
        s_d.sw_ctl.prio_ceiling = s_q.hpc2[`SPCS_B_PRIO_CEIL];
        s_d.sw_ctl.member = s_q.hpc2[2:0];
        s_d.link_up = stat_s_q.link_good;
        s_d.rx_link_mode = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.st <= SPCS_IDLE;
            s_q.ctrl4 <= `SPCS_CTRL4_RST;
            s_q.status <= `SPCS_STAT_RST;
            s_q.hpc2 <= `SPCS_HPC2_RST;
            s_q.phy_ctl <= `SPCS_PHY_CTL_RST;
            s_q.sw_ctl <= `SPCS_SW_CTL_RST;
        end
        else if (clk_en)
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign phy_ctl = s_q.phy_ctl;
    assign sw_ctl = s_q.sw_ctl;
    assign link_up = s_q.link_up;

endmodule

`default_nettype wire

// ### dv/spcs_regs_monitor.sv
// Purpose: Concurrent checks on the port register bank ports
// Assumes: Single pclk domain, presetn async active low
// Notes:   Status checks wait for a quiet PHY so sync latency never matters
`include "spcs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module spcs_regs_monitor
    import spcs_pkg::*;
(
    // Clock and reset
    input wire logic           pclk,
    input wire logic           presetn,
    input wire logic           clk_en,
    // APB
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [7:0]     paddr,
    input wire logic [31:0]    pwdata,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    // Port side
    input wire spcs_phy_stat_t phy_stat,
    input wire logic [33:0]    cnt_event,
    input wire spcs_phy_ctl_t  phy_ctl,
    input wire spcs_sw_ctl_t   sw_ctl,
    input wire logic           link_up
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Quiet-PHY counter, saturating so it never wraps back to zero
    logic [2:0]     stab_q;
    logic [2:0]     stab_d;
    spcs_phy_stat_t prev_q;

    always_comb
    begin
        // Frozen synchronisers lag the pins, so a stall restarts the count
        stab_d = (phy_stat != prev_q || !clk_en) ? 3'h0
                 : ((stab_q == 3'h7) ? stab_q : stab_q + 3'h1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stab_q <= 3'h0;
            prev_q <= '0;
        end
        else
        begin
            stab_q <= stab_d;
            prev_q <= phy_stat;
        end
    end

    function automatic spcs_sw_ctl_t sw_map(input logic [31:0] v);
        return {v[14:13], v[10:5], v[3:0]};
    endfunction

    function automatic logic [7:0] ctl_map(input logic [31:0] v);
        return {v[8:6], v[4:0]};
    endfunction

    sequence s_taken;
        psel && penable && !pready && clk_en;
    endsequence
    sequence s_status_read;
        pready && !pwrite && paddr == 8'h10 && stab_q >= 3'h6;
    endsequence

    property p_one_wait;
        s_taken |=> pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_unmapped;
        pready && (paddr == 8'h04 || paddr >= 8'h58) |-> pslverr && prdata == 32'h0;
    endproperty
    property p_err_only_ready;
        pslverr |-> pready;
    endproperty
    property p_hi_zero;
        pready && paddr != 8'h54 |-> prdata[31:16] == 16'h0;
    endproperty
    property p_stat_speed_dup;
        s_status_read |-> prdata[10:9] == {phy_stat.speed_100, phy_stat.full_duplex};
    endproperty
    property p_stat_flow_pol;
        s_status_read |-> prdata[14:11] ==
            {1'b0, phy_stat.polarity_rev, phy_stat.rx_flow_active, phy_stat.tx_flow_active};
    endproperty
    property p_stat_partner;
        s_status_read |-> prdata[8] == 1'b0 && prdata[4:0] == phy_stat.partner_abil;
    endproperty
    property p_sw_ctl_wr;
        s_taken ##0 (pwrite && paddr == 8'h28) |-> ##2 sw_ctl == sw_map($past(pwdata, 2));
    endproperty
    property p_phy_ctl_wr;
        s_taken ##0 (pwrite && paddr == 8'h00) |-> ##2
            {phy_ctl.far_loopback, phy_ctl.autoneg_en, phy_ctl.force_100, phy_ctl.advert}
            == ctl_map($past(pwdata, 2));
    endproperty
    property p_link;
        (clk_en && $stable(phy_stat.link_good)) [*5] |-> link_up == phy_stat.link_good;
    endproperty

    a_one_wait: assert property (p_one_wait) else $error("pready late");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped ok");
    a_err_only_ready: assert property (p_err_only_ready) else $error("stray pslverr");
    a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
    a_stat_speed_dup: assert property (p_stat_speed_dup) else $error("speed/duplex");
    a_stat_flow_pol: assert property (p_stat_flow_pol) else $error("flow/polarity");
    a_stat_partner: assert property (p_stat_partner) else $error("partner bits");
    a_sw_ctl_wr: assert property (p_sw_ctl_wr) else $error("sw_ctl stale");
    a_phy_ctl_wr: assert property (p_phy_ctl_wr) else $error("phy_ctl stale");
    a_link: assert property (p_link) else $error("link_up stale");
endmodule

`default_nettype wire

// ### dv/spcs_regs_bench.sv
// Purpose: Self-checking bench for the port register bank
// Assumes: One wait state APB slave; clk_en held high except in the clock enable test
// Notes:   Overflow needs 2^30 events, so only the valid flag is exercised
`include "spcs_map.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
        end \
    end

module spcs_regs_bench
    import spcs_pkg::*;
;
    logic           pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, link_up, xs;
    logic [7:0]     paddr;
    logic [31:0]    pwdata, prdata, w;
    logic [33:0]    cnt_event;
    logic [12:0]    r;
    spcs_phy_stat_t phy_stat;
    spcs_phy_ctl_t  phy_ctl;
    spcs_sw_ctl_t   sw_ctl;
    int             n_fail, cmp_count, n;
    logic [32:0]    exp_q[$];
    string          name_q[$];
    logic [7:0]     zr[5] = '{8'h20, 8'h30, 8'h38, 8'h40, 8'h48};

    spcs_regs u_spcs_regs (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phy_stat(phy_stat), .cnt_event(cnt_event),
        .phy_ctl(phy_ctl), .sw_ctl(sw_ctl), .link_up(link_up));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // One transfer; the expected answer is queued before the request goes out
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       input logic [32:0] e, input string nm);
        exp_q.push_back(e);
        name_q.push_back(nm);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(a, 1'b0, 32'h0, {1'b0, e}, nm);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 33'h0, "write");
    endtask

    task automatic settle();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic finish_test();
        // Let the response checker see the last answer first
        @(negedge pclk);
        if (exp_q.size() != 0)
        begin
            n_fail++;
            $display("MISMATCH pending answers exp 0 got %0d", exp_q.size());
        end
        $display("Counts: %0d compared, %0d failed", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        logic [32:0] e;
        string       nm;
        if (psel && penable && pready)
        begin
            e  = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h0;
            nm = (name_q.size() > 0) ? name_q.pop_front() : "unexpected";
            `CHK(nm, {pslverr, prdata}, e)
        end
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        $display("MISMATCH watchdog exp done got hang");
        finish_test();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, phy_stat, cnt_event} = '0;
        {clk_en, presetn, xs, n_fail, cmp_count} = {3'b101, 64'h0};
        void'($urandom(32'h0410));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        `CHK("phy_ctl reset", phy_ctl, 10'h13f)
        `CHK("sw_ctl reset", sw_ctl, 12'h307)
        rd(8'h00, 32'h0000_009f, "ctrl4 reset");
        rd(8'h10, 32'h0000_8000, "status reset");
        rd(8'h28, 32'h0000_0607, "hpc2 reset");
        foreach (zr[i])
            rd(zr[i], 32'h0, "host reg reset");
        apb(8'h04, 1'b0, 32'h0, {1'b1, 32'h0}, "unmapped rd");
        apb(8'h5c, 1'b1, 32'hffff_ffff, {1'b1, 32'h0}, "unmapped wr");
        $display("Test reset and decode done");
        for (int i = 0; i < 4; i++)
        begin
            w = (i == 0) ? 32'hffff_ffff : $urandom;
            wr(8'h28, w);
            rd(8'h28, w & `SPCS_HPC2_WMASK, "hpc2");
            settle();
            `CHK("sw_ctl", sw_ctl, {w[14:13], w[10:5], w[3:0]})
        end
        $display("Test host port control done");
        for (int i = 0; i < 4; i++)
        begin
            r = 13'($urandom);
            @(posedge pclk);
            phy_stat <= r;
            repeat (6) @(posedge pclk);
            rd(8'h10, {16'h0, xs, 1'b0, r[12:8], 1'b0, r[7:0]}, "status");
            `CHK("link_up", link_up, r[5])
            w = $urandom;
            wr(8'h10, w);
            xs = w[15];
            settle();
            `CHK("crossover", phy_ctl.crossover_style_select, xs)
        end
        $display("Test status done");
        for (int i = 0; i < 4; i++)
        begin
            w = $urandom;
            w[7] = i[0];
            wr(8'h00, w);
            rd(8'h00, {16'h0, w[15:0]}, "ctrl4");
            settle();
            `CHK("phy_ctl", phy_ctl, {w[8:6], w[5] && (!w[7] || (r[6] && !r[5])), w[4:0], xs})
        end
        $display("Test port control done");
        for (int s = 0; s < 34; s += 33)
        begin
            wr(8'h50, s);
            n = 1 + $urandom % 8;
            repeat (n)
            begin
                cnt_event <= 34'h1 << s;
                repeat (3) @(posedge pclk);
                cnt_event <= '0;
                repeat (3) @(posedge pclk);
            end
            rd(8'h54, {2'b01, 30'(n)}, "counter");
            rd(8'h54, 32'h4000_0000, "counter cleared");
        end
        wr(8'h50, 32'd34);
        rd(8'h54, 32'h0, "counter out of range");
        $display("Test counters done");
        clk_en <= 1'b0;
        phy_stat <= ~phy_stat;
        repeat (6) @(posedge pclk);
        `CHK("link_up frozen", link_up, r[5])
        clk_en <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK("link_up resumed", link_up, !r[5])
        $display("Test clock enable done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h28, 32'h0000_0607, "hpc2 second reset");
        $display("Test second reset done");
        finish_test();
    end
endmodule

bind spcs_regs spcs_regs_monitor u_spcs_regs_monitor (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phy_stat(phy_stat), .cnt_event(cnt_event), .phy_ctl(phy_ctl), .sw_ctl(sw_ctl),
    .link_up(link_up));

`default_nettype wire
